// ===== include/adcosc_pkg.sv
package adcosc_pkg;
    localparam logic [11:0] ADCOSC_OFF_CTRL_FIRST  = 12'h0D6 << 2;
    localparam logic [11:0] ADCOSC_OFF_CTRL_SECOND = 12'h0D7 << 2;
    localparam logic [11:0] ADCOSC_OFF_RESULT      = 12'h0D8 << 2;
    localparam logic [11:0] ADCOSC_OFF_STATUS      = 12'h0D9 << 2;
    localparam logic [7:0]  ADCOSC_RST_FIRST       = 8'h00;
    localparam logic [7:0]  ADCOSC_RST_SECOND      = 8'h00;
    // First control register fields
    localparam int ADCOSC_F_CH_LO    = 0;
    localparam int ADCOSC_F_MODE     = 3;
    localparam int ADCOSC_F_GRP_EN   = 4;
    localparam int ADCOSC_F_TRIG_SRC = 5;
    localparam int ADCOSC_F_START    = 6;
    localparam int ADCOSC_F_CKS_LO   = 7;
    // Second control register fields
    localparam int ADCOSC_F_RES      = 3;
    localparam int ADCOSC_F_CKS_HI   = 4;
    localparam int ADCOSC_F_REF_CON  = 5;
    localparam logic [2:0] ADCOSC_CH_FIRST = 3'h4;
    localparam logic [9:0] ADCOSC_FULL10   = 10'h3FF;
    localparam logic [9:0] ADCOSC_FULL8    = 10'h0FF;
    typedef enum logic [1:0] {
        ADCOSC_CLK_F4   = 2'b00,
        ADCOSC_CLK_F2   = 2'b01,
        ADCOSC_CLK_F1   = 2'b10,
        ADCOSC_CLK_RING = 2'b11
    } adcosc_clk_t;
    typedef enum logic [1:0] {
        ADCOSC_IDLE = 2'b00,
        ADCOSC_CONV = 2'b01,
        ADCOSC_DONE = 2'b10
    } adcosc_state_t;
endpackage : adcosc_pkg

// ===== src/adcosc_top.sv
// Implementation choice: the AXI4-Lite slave port.
module adcosc_top (
    input  wire logic        MCLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic [11:0] S_AXI_AWADDR_IN,
    input  wire logic        S_AXI_AWVALID_IN,
    output logic             S_AXI_AWREADY_OUT,
    input  wire logic [31:0] S_AXI_WDATA_IN,
    input  wire logic [3:0]  S_AXI_WSTRB_IN,
    input  wire logic        S_AXI_WVALID_IN,
    output logic             S_AXI_WREADY_OUT,
    output logic [1:0]       S_AXI_BRESP_OUT,
    output logic             S_AXI_BVALID_OUT,
    input  wire logic        S_AXI_BREADY_IN,
    input  wire logic [11:0] S_AXI_ARADDR_IN,
    input  wire logic        S_AXI_ARVALID_IN,
    output logic             S_AXI_ARREADY_OUT,
    output logic [31:0]      S_AXI_RDATA_OUT,
    output logic [1:0]       S_AXI_RRESP_OUT,
    output logic             S_AXI_RVALID_OUT,
    input  wire logic        S_AXI_RREADY_IN,
    input  wire logic        CAPTURE_REQ_IN,
    output logic             CONV_START_OUT,
    output logic             CONV_ABORT_OUT,
    input  wire logic        CONV_DONE_IN,
    input  wire logic [9:0]  CONV_DATA_IN,
    input  wire logic        CONV_OVER_REF_IN,
    output logic [3:0]       INPUT_SELECT_OUT,
    output logic             TEN_BIT_OUT,
    output logic [1:0]       CLOCK_SELECT_OUT,
    output logic             REF_CONNECT_OUT,
    output logic             CONV_BUSY_OUT,
    output logic             CONV_IRQ_OUT
);
    logic [7:0]                ctrl_first_ff;
    logic [7:0]                ctrl_second_ff;
    logic [9:0]                result_ff;
    adcosc_pkg::adcosc_state_t state_ff;
    logic                      aw_held_ff;
    logic                      w_held_ff;
    logic [11:0]               awaddr_ff;
    logic [31:0]               wdata_ff;
    logic [3:0]                wstrb_ff;
    logic                      bvalid_ff;
    logic [1:0]                bresp_ff;
    logic                      rvalid_ff;
    logic [31:0]               rdata_ff;
    logic [1:0]                rresp_ff;
    logic                      start_ff;
    logic                      abort_ff;
    logic                      irq_ff;
    logic [2:0]                cap_sync_ff;
    logic                      cap_level_ff;
    logic                      wr_fire;
    logic                      wr_first;
    logic                      wr_second;
    logic                      wr_start_one;
    logic                      wr_start_zero;
    logic                      cap_event;
    logic                      begin_conv;
    logic                      trig_capture;
    logic                      conv_end;
    logic [7:0]                ctrl_view;
    logic [3:0]                sel_ff;
    wire [3:0]                 nxt_sel;

    // Write channel acceptance, address and data in either order
    assign S_AXI_AWREADY_OUT = !aw_held_ff && !bvalid_ff;
    assign S_AXI_WREADY_OUT  = !w_held_ff && !bvalid_ff;
    assign S_AXI_BVALID_OUT  = bvalid_ff;
    assign S_AXI_BRESP_OUT   = bresp_ff;
    assign S_AXI_ARREADY_OUT = !rvalid_ff;
    assign S_AXI_RVALID_OUT  = rvalid_ff;
    assign S_AXI_RDATA_OUT   = rdata_ff;
    assign S_AXI_RRESP_OUT   = rresp_ff;

    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 12'h000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
        end else begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= S_AXI_WDATA_IN;
                wstrb_ff  <= S_AXI_WSTRB_IN;
            end
        end
    end

    // Register write decode, lane 0 carries the 8-bit registers
    assign wr_fire   = aw_held_ff && w_held_ff;
    assign wr_first  = wr_fire && wstrb_ff[0]
                       && (awaddr_ff[11:2] == adcosc_pkg::ADCOSC_OFF_CTRL_FIRST[11:2]);
    assign wr_second = wr_fire && wstrb_ff[0]
                       && (awaddr_ff[11:2] == adcosc_pkg::ADCOSC_OFF_CTRL_SECOND[11:2]);
    assign wr_start_one  = wr_first && wdata_ff[adcosc_pkg::ADCOSC_F_START];
    assign wr_start_zero = wr_first && !wdata_ff[adcosc_pkg::ADCOSC_F_START];

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= 2'b00;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (awaddr_ff[11:2] == adcosc_pkg::ADCOSC_OFF_CTRL_FIRST[11:2]
                          || awaddr_ff[11:2] == adcosc_pkg::ADCOSC_OFF_CTRL_SECOND[11:2])
                         ? 2'b00 : 2'b10;
        end else if (S_AXI_BREADY_IN) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read path, one cycle after address acceptance
    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= 2'b00;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= 2'b00;
            case (S_AXI_ARADDR_IN[11:2])
                adcosc_pkg::ADCOSC_OFF_CTRL_FIRST[11:2]:  rdata_ff <= {24'h000000, ctrl_first_ff};
                adcosc_pkg::ADCOSC_OFF_CTRL_SECOND[11:2]: rdata_ff <= {24'h000000, ctrl_second_ff};
                adcosc_pkg::ADCOSC_OFF_RESULT[11:2]:      rdata_ff <= {22'h000000, result_ff};
                adcosc_pkg::ADCOSC_OFF_STATUS[11:2]:      rdata_ff <= {30'h00000000, state_ff};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= 2'b10;
                end
            endcase
        end else if (S_AXI_RREADY_IN) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Capture request synchroniser, edge once stages two and three agree
    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            cap_sync_ff  <= 3'b000;
            cap_level_ff <= 1'b0;
        end else begin
            cap_sync_ff <= {cap_sync_ff[1:0], CAPTURE_REQ_IN};
            if (cap_sync_ff[2] == cap_sync_ff[1]) begin
                cap_level_ff <= cap_sync_ff[2];
            end
        end
    end
    assign cap_event = (cap_sync_ff[2] == cap_sync_ff[1]) && cap_sync_ff[2] && !cap_level_ff;

    // Start conditions per trigger source
    assign trig_capture = ctrl_first_ff[adcosc_pkg::ADCOSC_F_TRIG_SRC];
    // Start checks see a same-cycle write, so one write can enable and start
    assign ctrl_view  = wr_first ? wdata_ff[7:0] : ctrl_first_ff;
    assign begin_conv = (state_ff == adcosc_pkg::ADCOSC_IDLE)
                        && ctrl_view[adcosc_pkg::ADCOSC_F_GRP_EN]
                        && !ctrl_view[adcosc_pkg::ADCOSC_F_MODE]
                        && (ctrl_view[adcosc_pkg::ADCOSC_F_TRIG_SRC]
                            ? (cap_event && ctrl_view[adcosc_pkg::ADCOSC_F_START])
                            : wr_start_one);
    assign conv_end = (state_ff == adcosc_pkg::ADCOSC_CONV) && CONV_DONE_IN && !wr_start_zero;

    // Conversion sequencer: one conversion per start
    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            state_ff <= adcosc_pkg::ADCOSC_IDLE;
        end else begin
            case (state_ff)
                adcosc_pkg::ADCOSC_IDLE: begin
                    if (begin_conv) begin
                        state_ff <= adcosc_pkg::ADCOSC_CONV;
                    end
                end
                adcosc_pkg::ADCOSC_CONV: begin
                    if (wr_start_zero) begin
                        state_ff <= adcosc_pkg::ADCOSC_IDLE;
                    end else if (CONV_DONE_IN) begin
                        state_ff <= adcosc_pkg::ADCOSC_DONE;
                    end
                end
                adcosc_pkg::ADCOSC_DONE: state_ff <= adcosc_pkg::ADCOSC_IDLE;
                default: state_ff <= adcosc_pkg::ADCOSC_IDLE;
            endcase
        end
    end

    // Control registers; completion clears the start flag unless the capture trigger source is selected
    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            ctrl_first_ff  <= adcosc_pkg::ADCOSC_RST_FIRST;
            ctrl_second_ff <= adcosc_pkg::ADCOSC_RST_SECOND;
        end else begin
            if (wr_first) begin
                ctrl_first_ff <= wdata_ff[7:0];
            end
            if (wr_second) begin
                ctrl_second_ff <= wdata_ff[7:0];
            end
            if (conv_end && !trig_capture) begin
                ctrl_first_ff[adcosc_pkg::ADCOSC_F_START] <= 1'b0;
            end
        end
    end

    // Result capture with full-scale clamp
    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            result_ff <= 10'h000;
        end else if (conv_end) begin
            if (ctrl_second_ff[adcosc_pkg::ADCOSC_F_RES]) begin
                result_ff <= CONV_OVER_REF_IN ? adcosc_pkg::ADCOSC_FULL10 : CONV_DATA_IN;
            end else begin
                result_ff <= CONV_OVER_REF_IN ? adcosc_pkg::ADCOSC_FULL8
                                              : {2'b00, CONV_DATA_IN[9:2]};
            end
        end
    end

    // Core strobes and completion interrupt pulse
    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            start_ff <= 1'b0;
            abort_ff <= 1'b0;
            irq_ff   <= 1'b0;
        end else begin
            start_ff <= begin_conv;
            abort_ff <= (state_ff == adcosc_pkg::ADCOSC_CONV) && wr_start_zero;
            irq_ff   <= conv_end;
        end
    end

    assign CONV_START_OUT   = start_ff;
    assign CONV_ABORT_OUT   = abort_ff;
    assign CONV_IRQ_OUT     = irq_ff;
    assign CONV_BUSY_OUT    = (state_ff == adcosc_pkg::ADCOSC_CONV);
    // Input select decode: one line per input four..seven, all low when disabled
    for (genvar g = 0; g < 4; g++) begin : g_sel
        assign nxt_sel[g] = ctrl_first_ff[adcosc_pkg::ADCOSC_F_GRP_EN]
                            && ctrl_first_ff[2]
                            && (ctrl_first_ff[1:0] == 2'(g));
    end

    // Input select flops, so the mux never sees decode glitches
    always_ff @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            sel_ff <= 4'h0;
        end else begin
            sel_ff <= nxt_sel;
        end
    end
    assign INPUT_SELECT_OUT = sel_ff;
    assign TEN_BIT_OUT      = ctrl_second_ff[adcosc_pkg::ADCOSC_F_RES];
    assign CLOCK_SELECT_OUT = {ctrl_second_ff[adcosc_pkg::ADCOSC_F_CKS_HI],
                               ctrl_first_ff[adcosc_pkg::ADCOSC_F_CKS_LO]};
    assign REF_CONNECT_OUT  = ctrl_second_ff[adcosc_pkg::ADCOSC_F_REF_CON];
endmodule : adcosc_top

// ===== verif/adcosc_core_model.sv
module adcosc_core_model #(
    parameter int LAT = 20
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       start_in,
    input  wire logic       abort_in,
    input  wire logic [9:0] val_in,
    input  wire logic       ovr_in,
    output logic            done_out,
    output logic [9:0]      data_out,
    output logic            over_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_ff;
    // Conversion countdown, cancelled by abort
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || abort_in) begin
            cnt_ff <= 0;
        end else if (start_in) begin
            cnt_ff <= LAT;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    // Result valid with done only, inverted otherwise
    assign done_out = (cnt_ff == 1);
    assign data_out = done_out ? val_in : ~val_in;
    assign over_out = done_out ? ovr_in : ~ovr_in;
endmodule : adcosc_core_model

// ===== verif/adcosc_props.sv
module adcosc_props (
    input wire logic       MCLK_IN,
    input wire logic       RST_B_IN,
    input wire logic       S_AXI_BVALID_OUT,
    input wire logic       S_AXI_BREADY_IN,
    input wire logic       S_AXI_RVALID_OUT,
    input wire logic       S_AXI_RREADY_IN,
    input wire logic       CONV_START_OUT,
    input wire logic       CONV_ABORT_OUT,
    input wire logic       CONV_DONE_IN,
    input wire logic       CONV_BUSY_OUT,
    input wire logic       CONV_IRQ_OUT,
    input wire logic [3:0] INPUT_SELECT_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    // Completion seen while converting
    sequence s_done;
        CONV_BUSY_OUT && CONV_DONE_IN;
    endsequence
    a_start_busy: assert property (CONV_START_OUT |-> CONV_BUSY_OUT && !$past(CONV_BUSY_OUT))
        else $error("start without fresh busy");
    a_start_once: assert property (CONV_START_OUT |=> (!CONV_START_OUT)[*2])
        else $error("repeated start");
    a_busy_rise: assert property ($rose(CONV_BUSY_OUT) |-> CONV_START_OUT)
        else $error("busy without start");
    a_done_irq: assert property (s_done |=> (CONV_IRQ_OUT || CONV_ABORT_OUT) && !CONV_BUSY_OUT)
        else $error("no irq after done");
    a_irq_cause: assert property (CONV_IRQ_OUT |-> $past(CONV_DONE_IN) && $past(CONV_BUSY_OUT))
        else $error("irq without done");
    a_irq_single: assert property (CONV_IRQ_OUT |=> !CONV_IRQ_OUT)
        else $error("irq longer than one cycle");
    a_abort_stop: assert property (CONV_ABORT_OUT |=> !CONV_BUSY_OUT && !CONV_IRQ_OUT)
        else $error("conversion runs after abort");
    a_sel_onehot: assert property ($onehot0(INPUT_SELECT_OUT))
        else $error("input select not one-hot");
    a_rvalid_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT)
        else $error("read data dropped");
    a_bvalid_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
        else $error("write response dropped");
endmodule : adcosc_props

bind adcosc_top adcosc_props i_props (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN),
    .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .CONV_START_OUT(CONV_START_OUT), .CONV_ABORT_OUT(CONV_ABORT_OUT),
    .CONV_DONE_IN(CONV_DONE_IN), .CONV_BUSY_OUT(CONV_BUSY_OUT),
    .CONV_IRQ_OUT(CONV_IRQ_OUT), .INPUT_SELECT_OUT(INPUT_SELECT_OUT));

// ===== verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 20;
    localparam logic [11:0] A0 = adcosc_pkg::ADCOSC_OFF_CTRL_FIRST;
    localparam logic [11:0] A1 = adcosc_pkg::ADCOSC_OFF_CTRL_SECOND;
    logic clk = 0, rst_b = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, cap = 0, o = 0;
    logic awr, wr_r, bv, arr, rv, st, ab, dn, ov, ten, rc, busy, irq;
    logic [1:0] br, rr, cs;
    logic [1:0] qr[$];
    logic [3:0] sel;
    logic [9:0] dat, v = '0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat, q[$];
    int n_errors = 0, num_checks = 0, n_irq = 0;
    always #20 clk = ~clk;
    adcosc_top i_dut (.MCLK_IN(clk), .RST_B_IN(rst_b), .S_AXI_AWADDR_IN(awa),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
        .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_r),
        .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
        .S_AXI_RREADY_IN(rre), .CAPTURE_REQ_IN(cap), .CONV_START_OUT(st),
        .CONV_ABORT_OUT(ab), .CONV_DONE_IN(dn), .CONV_DATA_IN(dat), .CONV_OVER_REF_IN(ov),
        .INPUT_SELECT_OUT(sel), .TEN_BIT_OUT(ten), .CLOCK_SELECT_OUT(cs),
        .REF_CONNECT_OUT(rc), .CONV_BUSY_OUT(busy), .CONV_IRQ_OUT(irq));
    adcosc_core_model #(.LAT(LAT)) i_core (.clk_in(clk), .rst_b_in(rst_b), .start_in(st),
        .abort_in(ab), .val_in(v), .ovr_in(o), .done_out(dn), .data_out(dat), .over_out(ov));
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
        num_checks++;
        if (x !== y) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, x, y);
        end
    endtask : chk
    function automatic logic sig(input int k);
        case (k)
            0: return arr;
            1: return rv;
            2: return awr && wr_r;
            3: return bv;
            default: return irq;
        endcase
    endfunction : sig
    // Bounded wait for a handshake or completion
    task automatic wt(input int k);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            if (sig(k) === 1'b1) return;
        end
        n_errors++;
        summarize();
    endtask : wt
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] xr = 2'b00);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        // Each channel released at the edge where its own ready is seen
        for (int i = 0; i < 200 && (pa || pw); i++) begin
            @(posedge clk);
            if (pa && awr === 1'b1) begin
                awv <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wr_r === 1'b1) begin
                wv <= 1'b0;
                pw = 1'b0;
            end
        end
        if (pa || pw) begin
            n_errors++;
            summarize();
        end
        wt(3);
        chk("bresp", 32'(xr), 32'(br));
        bre <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [1:0] xr = 2'b00);
        q.push_back(x);
        qr.push_back(xr);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        wt(0);
        arv <= 1'b0;
        wt(1);
        rre <= 1'b0;
        @(posedge clk);
    endtask : rd
    // Read data checked against oldest note; interrupts counted
    always @(posedge clk) begin
        if (rv === 1'b1 && rre) begin
            chk("rdata", q.pop_front(), rdat);
            chk("rresp", 32'(qr.pop_front()), 32'(rr));
        end
        if (irq === 1'b1) n_irq++;
    end
    task automatic pulse_cap();
        cap <= 1'b1;
        repeat (3) @(posedge clk);
        cap <= 1'b0;
    endtask : pulse_cap
    initial begin
        logic [7:0] r;
        logic [31:0] x;
        int n;
        void'($urandom(2153));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        wr(12'hFF0, 8'hFF, 2'b10);
        rd(A0, 0);
        rd(A1, 0);
        rd(12'hFF0, 0, 2'b10);
        for (int c = 4; c < 8; c++) begin
            wr(A0, 8'h10 | 8'(c));
            chk("sel", 32'(1 << (c - 4)), 32'(sel));
            wr(A0, 8'(c));
            chk("sel", 0, 32'(sel));
        end
        for (int k = 0; k < 4; k++) begin
            r = 8'($urandom) & 8'h28;
            wr(A1, r | 8'((k >> 1) << 4));
            wr(A0, 8'((k & 1) << 7));
            chk("clk", 32'(k), 32'(cs));
            chk("res", 32'(r[3]), 32'(ten));
            chk("ref", 32'(r[5]), 32'(rc));
        end
        for (int j = 0; j < 4; j++) begin
            v <= 10'($urandom);
            o <= j[1];
            wr(A1, 8'h20 | (8'(j[0]) << 3));
            repeat (25) @(posedge clk);
            wr(A0, 8'h55);
            wt(4);
            if (o) x = j[0] ? 32'(adcosc_pkg::ADCOSC_FULL10) : 32'(adcosc_pkg::ADCOSC_FULL8);
            else x = j[0] ? 32'(v) : 32'(v[9:2]);
            rd(adcosc_pkg::ADCOSC_OFF_RESULT, x);
            rd(A0, 32'h15);
        end
        // Abort mid-conversion
        wr(A0, 8'h55);
        n = n_irq;
        wr(A0, 8'h15);
        repeat (LAT + 4) @(posedge clk);
        chk("busy", 0, 32'(busy));
        chk("irq", n, n_irq);
        // Capture start with flag set, then with flag clear
        wr(A0, 8'h75);
        pulse_cap();
        wt(4);
        rd(A0, 32'h75);
        wr(A0, 8'h35);
        n = n_irq;
        pulse_cap();
        repeat (LAT + 8) @(posedge clk);
        chk("irq", n, n_irq);
        wr(A1, 8'h20);
        wr(A0, 8'h5D);
        repeat (LAT + 4) @(posedge clk);
        chk("irq", n, n_irq);
        wr(A1, 8'h30);
        rd(A1, 32'h30);
        chk("clk", 2, 32'(cs));
        summarize();
    end
endmodule : tb_top
